// [core/energy_accum_pkg.sv]
/*
 * shared constants, field positions, mode encodings and carrier structs for
 * the energy accumulation mode control block.
 * assumes one system clock; samples arrive from the dsp on that clock.
 */
package energy_accum_pkg;

    // ****************************************
    // widths
    // ****************************************
    localparam int SAMPLE_W = 24;
    localparam int PROD_W = 2 * SAMPLE_W;
    localparam int ENERGY_W = 64;
    localparam int CONFIG_W = 8;
    localparam int STATUS_W = 32;
    localparam int ADDR_W = 16;

    // ****************************************
    // register map
    // ****************************************
    localparam logic [ADDR_W-1:0] ACCUM_MODE_CONFIG_ADDR = 16'he701;
    localparam logic [ADDR_W-1:0] STATUS_WORD_FIRST_ADDR = 16'he502;
    localparam logic [CONFIG_W-1:0] ACCUM_MODE_CONFIG_RESET = 8'h00;
    localparam logic [STATUS_W-1:0] STATUS_WORD_FIRST_RESET = 32'h0000_0000;

    // ****************************************
    // field positions
    // ****************************************
    localparam int ACTIVE_MODE_LSB = 0;
    localparam int REACTIVE_MODE_LSB = 2;
    localparam int WIRING_LSB = 4;
    localparam int REV_SRC_BIT = 6;
    localparam int REV_FLAG_BIT = 6;

    // ****************************************
    // mode encodings
    // ****************************************
    typedef enum logic [1:0] {
        ACT_SIGNED = 2'b00,
        ACT_RESERVED_1 = 2'b01,
        ACT_RESERVED_2 = 2'b10,
        ACT_ABSOLUTE = 2'b11
    } active_accum_mode_t;

    typedef enum logic [1:0] {
        REACT_SIGNED = 2'b00,
        REACT_RESERVED_1 = 2'b01,
        REACT_FOLLOW_ACTIVE = 2'b10,
        REACT_RESERVED_3 = 2'b11
    } reactive_accum_mode_t;

    typedef enum logic [1:0] {
        WIRE_4W_3V = 2'b00,
        WIRE_3W_DELTA = 2'b01,
        WIRE_4W_2V = 2'b10,
        WIRE_4W_DELTA = 2'b11
    } wiring_config_select_t;

    // ****************************************
    // carriers
    // ****************************************
    typedef struct packed {
        logic signed [SAMPLE_W-1:0] volt;
        logic signed [SAMPLE_W-1:0] curr;
        logic signed [SAMPLE_W-1:0] curr_quad;
        logic signed [SAMPLE_W-1:0] volt_fund;
        logic signed [SAMPLE_W-1:0] curr_fund;
        logic signed [SAMPLE_W-1:0] curr_quad_fund;
        logic [SAMPLE_W-1:0] volt_rms;
        logic [SAMPLE_W-1:0] curr_rms;
    } phase_sample_t;

    typedef struct packed {
        logic signed [ENERGY_W-1:0] active;
        logic signed [ENERGY_W-1:0] active_fund;
        logic signed [ENERGY_W-1:0] reactive;
        logic signed [ENERGY_W-1:0] reactive_fund;
        logic [ENERGY_W-1:0] apparent;
    } phase_energy_t;

endpackage

// [core/energy_accumulation_mode_control.sv]
/*
 * accumulation mode configuration register, phase b voltage substitution,
 * three energy lanes and the phase a active power reversal flag.
 * assumes the serial port front end presents decoded register accesses on
 * the system clock, and the dsp supplies samples on that same clock.
 */
`timescale 1ns/10ps

module energy_accumulation_mode_control
    import energy_accum_pkg::*;
(
    // clock and reset
    input wire logic mclk_in,
    input wire logic rst_n_in,
    // register access from the serial port
    input wire logic [energy_accum_pkg::ADDR_W-1:0] reg_addr_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [energy_accum_pkg::STATUS_W-1:0] reg_wdata_in,
    output logic [energy_accum_pkg::STATUS_W-1:0] reg_rdata_out,
    output logic reg_rvalid_out,
    // samples from the dsp
    input wire logic sample_valid_in,
    input wire energy_accum_pkg::phase_sample_t phase_a_in,
    input wire energy_accum_pkg::phase_sample_t phase_b_in,
    input wire energy_accum_pkg::phase_sample_t phase_c_in,
    // energies
    output energy_accum_pkg::phase_energy_t energy_a_out,
    output energy_accum_pkg::phase_energy_t energy_b_out,
    output energy_accum_pkg::phase_energy_t energy_c_out,
    // status
    output logic phase_a_active_reversal_flag_out
);
    import energy_accum_pkg::*;

    // ****************************************
    // configuration register
    // ****************************************
    logic [CONFIG_W-1:0] accumulation_mode_config;
    logic [STATUS_W-1:0] status_word_first;
    active_accum_mode_t active_accum_mode;
    reactive_accum_mode_t reactive_accum_mode;
    wiring_config_select_t wiring_config_select;
    logic active_reversal_source_select;

    always_ff @(posedge mclk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            accumulation_mode_config <= ACCUM_MODE_CONFIG_RESET;
        else if (reg_wr_in && reg_addr_in == ACCUM_MODE_CONFIG_ADDR)
            accumulation_mode_config <= reg_wdata_in[CONFIG_W-1:0];
    end

    // reserved codes are stored as written, so software reads them back
    assign active_accum_mode =
        active_accum_mode_t'(accumulation_mode_config[ACTIVE_MODE_LSB +: 2]);
    assign reactive_accum_mode =
        reactive_accum_mode_t'(accumulation_mode_config[REACTIVE_MODE_LSB +: 2]);
    assign wiring_config_select =
        wiring_config_select_t'(accumulation_mode_config[WIRING_LSB +: 2]);
    assign active_reversal_source_select = accumulation_mode_config[REV_SRC_BIT];

    // ****************************************
    // read path
    // ****************************************
    always_ff @(posedge mclk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            reg_rdata_out <= '0;
            reg_rvalid_out <= 1'b0;
        end
        else
        begin
            reg_rvalid_out <= reg_rd_in;
            if (reg_rd_in)
            begin
                if (reg_addr_in == ACCUM_MODE_CONFIG_ADDR)
                    reg_rdata_out <= {{(STATUS_W-CONFIG_W){1'b0}}, accumulation_mode_config};
                else if (reg_addr_in == STATUS_WORD_FIRST_ADDR)
                    reg_rdata_out <= status_word_first;
                else
                    reg_rdata_out <= '0;
            end
        end
    end

    // ****************************************
    // phase b voltage substitution
    // ****************************************
    // derived voltages wrap at the sample width; the dsp keeps headroom
    phase_sample_t lane_b_sample;
    logic phase_b_zero;

    always_comb
    begin
        lane_b_sample = phase_b_in;
        phase_b_zero = 1'b0;
        case (wiring_config_select)
            WIRE_3W_DELTA:
            begin
                phase_b_zero = 1'b1;
            end
            WIRE_4W_2V:
            begin
                lane_b_sample.volt = SAMPLE_W'(-phase_a_in.volt - phase_c_in.volt);
                lane_b_sample.volt_fund =
                    SAMPLE_W'(-phase_a_in.volt_fund - phase_c_in.volt_fund);
            end
            WIRE_4W_DELTA:
            begin
                lane_b_sample.volt = SAMPLE_W'(-phase_a_in.volt);
                lane_b_sample.volt_fund = SAMPLE_W'(-phase_a_in.volt_fund);
            end
            default:
            begin
                lane_b_sample = phase_b_in;
            end
        endcase
    end

    // ****************************************
    // energy lanes
    // ****************************************
    logic signed [PROD_W-1:0] a_active_total;
    logic signed [PROD_W-1:0] a_active_fund;

    energy_lane lane_a (
        .mclk_in(mclk_in),
        .rst_n_in(rst_n_in),
        .sample_valid_in(sample_valid_in),
        .sample_in(phase_a_in),
        .force_zero_in(1'b0),
        .active_mode_in(active_accum_mode),
        .reactive_mode_in(reactive_accum_mode),
        .active_total_out(a_active_total),
        .active_fund_out(a_active_fund),
        .energy_out(energy_a_out)
    );

    energy_lane lane_b (
        .mclk_in(mclk_in),
        .rst_n_in(rst_n_in),
        .sample_valid_in(sample_valid_in),
        .sample_in(lane_b_sample),
        .force_zero_in(phase_b_zero),
        .active_mode_in(active_accum_mode),
        .reactive_mode_in(reactive_accum_mode),
        .active_total_out(),
        .active_fund_out(),
        .energy_out(energy_b_out)
    );

    energy_lane lane_c (
        .mclk_in(mclk_in),
        .rst_n_in(rst_n_in),
        .sample_valid_in(sample_valid_in),
        .sample_in(phase_c_in),
        .force_zero_in(1'b0),
        .active_mode_in(active_accum_mode),
        .reactive_mode_in(reactive_accum_mode),
        .active_total_out(),
        .active_fund_out(),
        .energy_out(energy_c_out)
    );

    // ****************************************
    // phase a active power reversal
    // ****************************************
    logic rev_power_sign;
    logic prev_sign;
    logic prev_sign_valid;
    logic reversal_event;
    logic reversal_clear;

    // bit 6 set picks the fundamental power instead
    assign rev_power_sign = active_reversal_source_select ?
        a_active_fund[PROD_W-1] : a_active_total[PROD_W-1];
    assign reversal_event = sample_valid_in && prev_sign_valid && (rev_power_sign != prev_sign);
    assign reversal_clear = reg_wr_in && reg_addr_in == STATUS_WORD_FIRST_ADDR
        && reg_wdata_in[REV_FLAG_BIT];

    always_ff @(posedge mclk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            prev_sign <= 1'b0;
            prev_sign_valid <= 1'b0;
        end
        else if (sample_valid_in)
        begin
            prev_sign <= rev_power_sign;
            prev_sign_valid <= 1'b1;
        end
    end

    // a sign change in the clearing cycle still sets the flag
    always_ff @(posedge mclk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            status_word_first <= STATUS_WORD_FIRST_RESET;
        else if (reversal_event)
            status_word_first[REV_FLAG_BIT] <= 1'b1;
        else if (reversal_clear)
            status_word_first[REV_FLAG_BIT] <= 1'b0;
    end

    assign phase_a_active_reversal_flag_out = status_word_first[REV_FLAG_BIT];

endmodule

// [core/energy_lane.sv]
/*
 * one phase of energy accumulation: forms the products, applies the
 * accumulation modes and integrates them on each sample strobe.
 * assumes the parent has already substituted the phase voltage.
 */
`timescale 1ns/10ps

module energy_lane
    import energy_accum_pkg::*;
(
    // clock and reset
    input wire logic mclk_in,
    input wire logic rst_n_in,
    // sample stream
    input wire logic sample_valid_in,
    input wire energy_accum_pkg::phase_sample_t sample_in,
    input wire logic force_zero_in,
    // modes
    input wire energy_accum_pkg::active_accum_mode_t active_mode_in,
    input wire energy_accum_pkg::reactive_accum_mode_t reactive_mode_in,
    // results
    output logic signed [energy_accum_pkg::PROD_W-1:0] active_total_out,
    output logic signed [energy_accum_pkg::PROD_W-1:0] active_fund_out,
    output energy_accum_pkg::phase_energy_t energy_out
);
    import energy_accum_pkg::*;

    // ****************************************
    // mode functions
    // ****************************************
    function automatic logic signed [ENERGY_W-1:0] widen(input logic signed [PROD_W-1:0] p);
        widen = {{(ENERGY_W-PROD_W){p[PROD_W-1]}}, p};
    endfunction

    function automatic logic signed [ENERGY_W-1:0] shape_active(
        input logic signed [PROD_W-1:0] p,
        input active_accum_mode_t mode
    );
        logic signed [ENERGY_W-1:0] w;
        w = widen(p);
        if (mode == ACT_ABSOLUTE && w < 0)
            shape_active = -w;
        else
            shape_active = w;
    endfunction

    function automatic logic signed [ENERGY_W-1:0] shape_reactive(
        input logic signed [PROD_W-1:0] q,
        input logic signed [PROD_W-1:0] p,
        input reactive_accum_mode_t mode
    );
        logic signed [ENERGY_W-1:0] w;
        w = widen(q);
        if (mode == REACT_FOLLOW_ACTIVE && p < 0)
            shape_reactive = -w;
        else
            shape_reactive = w;
    endfunction

    // ****************************************
    // products
    // ****************************************
    logic signed [PROD_W-1:0] react_total;
    logic signed [PROD_W-1:0] react_fund;
    logic [PROD_W-1:0] apparent_prod;

    always_comb
    begin
        if (force_zero_in)
        begin
            active_total_out = '0;
            active_fund_out = '0;
            react_total = '0;
            react_fund = '0;
            apparent_prod = '0;
        end
        else
        begin
            active_total_out = sample_in.volt * sample_in.curr;
            active_fund_out = sample_in.volt_fund * sample_in.curr_fund;
            react_total = sample_in.volt * sample_in.curr_quad;
            react_fund = sample_in.volt_fund * sample_in.curr_quad_fund;
            apparent_prod = sample_in.volt_rms * sample_in.curr_rms;
        end
    end

    // ****************************************
    // integrators
    // ****************************************
    always_ff @(posedge mclk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            energy_out <= '0;
        else if (sample_valid_in)
        begin
            energy_out.active <= energy_out.active
                + shape_active(active_total_out, active_mode_in);
            energy_out.active_fund <= energy_out.active_fund
                + shape_active(active_fund_out, active_mode_in);
            energy_out.reactive <= energy_out.reactive
                + shape_reactive(react_total, active_total_out, reactive_mode_in);
            energy_out.reactive_fund <= energy_out.reactive_fund
                + shape_reactive(react_fund, active_fund_out, reactive_mode_in);
            energy_out.apparent <= energy_out.apparent
                + {{(ENERGY_W-PROD_W){1'b0}}, apparent_prod};
        end
    end

endmodule

// [verification/energy_accum_props.sv]
/* checker for the accumulation mode block: modes, wiring, reversal flag.
   assumes it is bound to the top module and sees its ports only. */
`timescale 1ns/10ps
module energy_accum_props
    import energy_accum_pkg::*;
(
    // clock, reset, register port
    input wire logic mclk_in,
    input wire logic rst_n_in,
    input wire logic [energy_accum_pkg::ADDR_W-1:0] reg_addr_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [energy_accum_pkg::STATUS_W-1:0] reg_wdata_in,
    input wire logic [energy_accum_pkg::STATUS_W-1:0] reg_rdata_out,
    input wire logic reg_rvalid_out,
    // samples, energies, status
    input wire logic sample_valid_in,
    input wire energy_accum_pkg::phase_sample_t phase_a_in,
    input wire energy_accum_pkg::phase_sample_t phase_b_in,
    input wire energy_accum_pkg::phase_sample_t phase_c_in,
    input wire energy_accum_pkg::phase_energy_t energy_a_out,
    input wire energy_accum_pkg::phase_energy_t energy_b_out,
    input wire energy_accum_pkg::phase_energy_t energy_c_out,
    input wire logic phase_a_active_reversal_flag_out
);
    logic [7:0] cfg;
    logic prev, seen, clr, flip;
    logic signed [23:0] vb;
    logic signed [47:0] pa, pf, pb, pc;
    logic signed [63:0] da, dq, db, dc;
    // shadow of the config so checks see the mode the logic uses
    always_ff @(posedge mclk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            cfg <= 8'h00;
        else if (reg_wr_in && reg_addr_in == ACCUM_MODE_CONFIG_ADDR)
            cfg <= reg_wdata_in[7:0];
    end
    always_ff @(posedge mclk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            {prev, seen} <= 2'b00;
        else if (sample_valid_in)
            {prev, seen} <= {cfg[6] ? pf[47] : pa[47], 1'b1};
    end
    always_comb
    begin
        vb = cfg[5:4] == 2'b11 ? -phase_a_in.volt : cfg[5:4] == 2'b10 ?
            -phase_a_in.volt - phase_c_in.volt : phase_b_in.volt;
        pa = phase_a_in.volt * phase_a_in.curr;
        pf = phase_a_in.volt_fund * phase_a_in.curr_fund;
        pb = vb * phase_b_in.curr;
        pc = phase_c_in.volt * phase_c_in.curr;
        da = (cfg[1:0] == 2'b11 && pa[47]) ? -pa : pa;
        db = (cfg[1:0] == 2'b11 && pb[47]) ? -pb : pb;
        dc = (cfg[1:0] == 2'b11 && pc[47]) ? -pc : pc;
        dq = phase_a_in.volt * phase_a_in.curr_quad;
        dq = (cfg[3:2] == 2'b10 && pa[47]) ? -dq : dq;
        clr = reg_wr_in && reg_addr_in == STATUS_WORD_FIRST_ADDR && reg_wdata_in[6];
        flip = sample_valid_in && seen && (cfg[6] ? pf[47] : pa[47]) != prev;
    end
    default clocking @(posedge mclk_in); endclocking
    default disable iff (!rst_n_in);
    sequence s_smp;
        sample_valid_in;
    endsequence
    sequence s_rdc;
        reg_rd_in && reg_addr_in == ACCUM_MODE_CONFIG_ADDR;
    endsequence
    // phase b samples split by whether the wiring feeds the lane at all
    sequence s_smp_b;
        sample_valid_in && cfg[5:4] != 2'b01;
    endsequence
    sequence s_smp_z;
        sample_valid_in && cfg[5:4] == 2'b01;
    endsequence
    AST_CFG_READBACK: assert property (s_rdc |=> reg_rvalid_out &&
        reg_rdata_out == {24'h0, $past(cfg)}) else $error("config readback wrong");
    AST_A_ACTIVE: assert property (s_smp |=> energy_a_out.active ==
        $past(energy_a_out.active) + $past(da)) else $error("phase a active wrong");
    AST_A_REACT: assert property (s_smp |=> energy_a_out.reactive ==
        $past(energy_a_out.reactive) + $past(dq)) else $error("phase a reactive wrong");
    AST_A_APPARENT: assert property (s_smp |=> energy_a_out.apparent ==
        $past(energy_a_out.apparent) + $past(phase_a_in.volt_rms) * $past(phase_a_in.curr_rms))
        else $error("phase a apparent wrong");
    AST_C_ACTIVE: assert property (s_smp |=> energy_c_out.active ==
        $past(energy_c_out.active) + $past(dc)) else $error("phase c active wrong");
    AST_B_ACTIVE: assert property (s_smp_b |=>
        energy_b_out.active == $past(energy_b_out.active) + $past(db))
        else $error("phase b active wrong");
    AST_B_ZERO: assert property (s_smp_z |=>
        $stable(energy_b_out)) else $error("phase b moved in three wire delta");
    AST_FLAG_SET: assert property (flip |=> phase_a_active_reversal_flag_out)
        else $error("reversal not flagged");
    AST_FLAG_HOLD: assert property (phase_a_active_reversal_flag_out && !clr |=>
        phase_a_active_reversal_flag_out) else $error("reversal flag dropped");
    AST_FLAG_CLEAR: assert property (clr && !flip |=>
        !phase_a_active_reversal_flag_out) else $error("reversal flag not cleared");
endmodule
bind energy_accumulation_mode_control energy_accum_props u_props (
    .mclk_in(mclk_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_wdata_in(reg_wdata_in),
    .reg_rdata_out(reg_rdata_out), .reg_rvalid_out(reg_rvalid_out),
    .sample_valid_in(sample_valid_in), .phase_a_in(phase_a_in), .phase_b_in(phase_b_in),
    .phase_c_in(phase_c_in), .energy_a_out(energy_a_out), .energy_b_out(energy_b_out),
    .energy_c_out(energy_c_out),
    .phase_a_active_reversal_flag_out(phase_a_active_reversal_flag_out)
);

// [verification/energy_accumulation_mode_control_tb.sv]
/* self-checking bench: every code of config bits 6:0 (bit 7 follows bit 0), random samples, status flag.
   assumes the design package and the bound checker are compiled first. */
`timescale 1ns/10ps
module energy_accumulation_mode_control_tb;
    import energy_accum_pkg::*;
    logic mclk_in = 0, rst_n_in = 0, reg_wr_in = 0, reg_rd_in = 0;
    logic sample_valid_in = 0, s_d = 0, flag = 0, prev = 0, seen = 0, reg_rvalid_out;
    logic phase_a_active_reversal_flag_out;
    logic [ADDR_W-1:0] reg_addr_in = '0;
    logic [STATUS_W-1:0] reg_wdata_in = '0, reg_rdata_out;
    logic [7:0] cfg = 8'h00;
    logic [31:0] rng = 32'h0000_2d8e;
    phase_sample_t pa = '0, pb = '0, pc = '0;
    phase_energy_t ea_out, eb_out, ec_out, ea = '0, eb = '0, ec = '0;
    logic [31:0] rq[$];
    logic [959:0] eq[$];
    int fail_count = 0, check_count = 0;
    always #12.5 mclk_in = ~mclk_in;
    energy_accumulation_mode_control DUT (
        .mclk_in(mclk_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr_in),
        .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_wdata_in(reg_wdata_in),
        .reg_rdata_out(reg_rdata_out), .reg_rvalid_out(reg_rvalid_out),
        .sample_valid_in(sample_valid_in), .phase_a_in(pa), .phase_b_in(pb),
        .phase_c_in(pc), .energy_a_out(ea_out), .energy_b_out(eb_out),
        .energy_c_out(ec_out),
        .phase_a_active_reversal_flag_out(phase_a_active_reversal_flag_out)
    );
    function automatic logic [31:0] xs();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction
    function automatic logic signed [63:0] am(input logic signed [47:0] p);
        return (cfg[1:0] == 2'b11 && p[47]) ? -p : p;
    endfunction
    function automatic logic signed [63:0] rm(input logic signed [47:0] q, p);
        return (cfg[3:2] == 2'b10 && p[47]) ? -q : q;
    endfunction
    task automatic tick();
        @(posedge mclk_in);
        #1;
    endtask
    task automatic chk(input logic [959:0] got, exp);
        check_count++;
        if (got !== exp)
        begin
            fail_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic acc(inout phase_energy_t e, input phase_sample_t s,
                       input logic signed [23:0] v, vf);
        logic signed [47:0] p, pf;
        p = v * s.curr;
        pf = vf * s.curr_fund;
        e.active += am(p);
        e.active_fund += am(pf);
        e.reactive += rm(v * s.curr_quad, p);
        e.reactive_fund += rm(vf * s.curr_quad_fund, pf);
        e.apparent += s.volt_rms * s.curr_rms;
    endtask
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        reg_addr_in = a;
        reg_wdata_in = d;
        reg_wr_in = 1;
        tick();
        reg_wr_in = 0;
        tick();
    endtask
    task automatic rd(input logic [15:0] a, input logic [31:0] x);
        reg_addr_in = a;
        reg_rd_in = 1;
        rq.push_back(x);
        tick();
        reg_rd_in = 0;
        tick();
    endtask
    // back-to-back samples; ends share a sign so the flag source swap is neutral
    task automatic smp(input int n);
        logic signed [23:0] vb, vbf;
        logic signed [47:0] p;
        for (int j = 0; j < n; j++)
        begin
            pa = {xs(), xs(), xs(), xs(), xs(), xs()};
            pb = {xs(), xs(), xs(), xs(), xs(), xs()};
            pc = {xs(), xs(), xs(), xs(), xs(), xs()};
            if (j == 0 || j == n - 1)
                {pa.volt_fund, pa.curr_fund} = {pa.volt, pa.curr};
            vb = cfg[5:4] == 2'b11 ? -pa.volt : cfg[5:4] == 2'b10 ? -pa.volt - pc.volt : pb.volt;
            vbf = cfg[5:4] == 2'b11 ? -pa.volt_fund : cfg[5:4] == 2'b10 ?
                -pa.volt_fund - pc.volt_fund : pb.volt_fund;
            acc(ea, pa, pa.volt, pa.volt_fund);
            if (cfg[5:4] != 2'b01)
                acc(eb, pb, vb, vbf);
            acc(ec, pc, pc.volt, pc.volt_fund);
            eq.push_back({ea, eb, ec});
            p = cfg[6] ? pa.volt_fund * pa.curr_fund : pa.volt * pa.curr;
            if (seen && p[47] != prev)
                flag = 1;
            {prev, seen} = {p[47], 1'b1};
            sample_valid_in = 1;
            tick();
        end
        sample_valid_in = 0;
        tick();
    endtask
    always @(posedge mclk_in)
    begin
        if (reg_rvalid_out === 1'b1)
            chk(reg_rdata_out, rq.pop_front());
        if (s_d)
            chk({ea_out, eb_out, ec_out}, eq.pop_front());
        s_d = sample_valid_in;
    end
    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // 15 cycles per config pass, so 6000 cycles is ample
    initial
    begin
        #(25 * 6000);
        fail_count++;
        final_report();
    end
    initial
    begin
        logic [31:0] d;
        repeat (8) @(posedge mclk_in);
        #1;
        rst_n_in = 1;
        rd(ACCUM_MODE_CONFIG_ADDR, 32'h0);
        rd(16'h1234, 32'h0);
        for (int k = 0; k < 128; k++)
        begin
            cfg = {k[0], k[6:0]};
            d = xs();
            d[7:0] = cfg;
            wr(ACCUM_MODE_CONFIG_ADDR, d);
            rd(ACCUM_MODE_CONFIG_ADDR, {24'h0, cfg});
            smp(4);
            rd(STATUS_WORD_FIRST_ADDR, {25'h0, flag, 6'h0});
            wr(STATUS_WORD_FIRST_ADDR, k[0] ? 32'h40 : 32'hffff_ffbf);
            if (k[0])
                flag = 0;
            rd(STATUS_WORD_FIRST_ADDR, {25'h0, flag, 6'h0});
        end
        final_report();
    end
endmodule
